/* dv/adc_chk.sv */
// Checker for the converter control, watching the top module's ports only.
// Assumes one clock domain and a host clock sampled as a plain level.
`timescale 1ns/1ns
`default_nettype none
module adc_chk (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic conversion_trigger_i,
	input wire logic serial_clock_i,
	input wire logic [11:0] approximation_register_o,
	input wire logic sample_hold_o,
	input wire logic converting_o,
	input wire logic serial_data_o,
	input wire logic serial_data_oe_o,
	input wire logic light_powerdown_o,
	input wire logic deep_powerdown_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0] busy_len;
	// Length of the running conversion; a short or stuck sequencer shows here
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
		if (!rst_n_i)
			busy_len <= 8'h00;
		else
			busy_len <= converting_o ? busy_len + 8'h01 : 8'h00;
	start_edge_a: assert property ($rose(converting_o) |->
		$past(conversion_trigger_i) && !$past(conversion_trigger_i, 2)) else $error("start without edge");
	start_clear_a: assert property ($rose(converting_o) |->
		approximation_register_o == 12'h000 && !sample_hold_o) else $error("register not cleared");
	trial_order_a: assert property ($rose(converting_o) |-> ##12 approximation_register_o ==
		12'h800 ##10 approximation_register_o[10:0] == 11'h400) else $error("trial order wrong");
	busy_length_a: assert property ($fell(converting_o) |->
		busy_len == 8'h85) else $error("conversion length wrong");
	frame_open_a: assert property ($rose(serial_data_oe_o) |->
		$past(serial_clock_i) && !$past(serial_clock_i, 2)) else $error("pin driven off clock");
	bit_step_a: assert property (serial_data_oe_o && $changed(serial_data_o) |->
		$past(serial_clock_i) && !$past(serial_clock_i, 2)) else $error("bit changed off clock");
	deep_entry_a: assert property ($rose(deep_powerdown_o) |-> $past(light_powerdown_o) &&
		!light_powerdown_o && !$past(serial_clock_i)) else $error("deep entry wrong");
	wake_up_a: assert property ((light_powerdown_o || deep_powerdown_o) && serial_clock_i ##1
		serial_clock_i [*4] |=> !light_powerdown_o && !deep_powerdown_o) else $error("no wake");
	cover property ($fell(converting_o));
	cover property ($rose(deep_powerdown_o));
	cover property ($fell(serial_data_oe_o));
endmodule
bind sar_adc_serial_control adc_chk chk_u (.clk_sys_i, .rst_n_i, .conversion_trigger_i,
	.serial_clock_i, .approximation_register_o, .sample_hold_o, .converting_o, .serial_data_o,
	.serial_data_oe_o, .light_powerdown_o, .deep_powerdown_o);
`default_nettype wire

/* dv/host_reader.sv */
// Host side of the serial link: makes the serial clock and collects words.
// Assumes the bench clock; the serial clock idles high so it never counts pulses.
`timescale 1ns/1ns
`default_nettype none
module host_reader (
	input wire logic clk_sys_i,
	input wire logic pin_i,
	input wire logic oe_i,
	output logic serial_clock_o
);
	initial serial_clock_o = 1'b1;
	task automatic park(input logic level);
		serial_clock_o <= level;
	endtask
	// Fourteen rising edges, 50 ns low and 60 ns high; each bit taken between edges
	task automatic read_word(output logic [12:0] word, output logic lost);
		word = 13'h0000;
		lost = 1'b0;
		for (int i = 0; i < 14; i++)
		begin
			serial_clock_o <= 1'b0;
			repeat (5) @(posedge clk_sys_i);
			serial_clock_o <= 1'b1;
			repeat (5) @(posedge clk_sys_i);
			@(negedge clk_sys_i);
			if (i < 13)
				word = {word[11:0], pin_i};
			lost = lost | (i < 13 ? !oe_i : oe_i);
			@(posedge clk_sys_i);
		end
	endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Bench for the converter control: conversions, restarts, power-down, buffer.
// Assumes the host reader model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic conversion_trigger_i = 1'b0;
	logic comparator_i = 1'b0;
	logic reference_ok_i = 1'b1;
	logic bipolar_i = 1'b0;
	logic [11:0] analog_input = 12'h000;
	logic [11:0] approximation_register_o;
	logic sample_hold_o, converting_o, serial_data_o, serial_data_oe_o;
	logic light_powerdown_o, deep_powerdown_o;
	wire logic serial_clock_i;
	wire logic pin;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	sar_adc_serial_control dut_u (.clk_sys_i, .rst_n_i, .conversion_trigger_i, .serial_clock_i,
		.comparator_i, .reference_ok_i, .bipolar_i, .approximation_register_o, .sample_hold_o,
		.converting_o, .serial_data_o, .serial_data_oe_o, .light_powerdown_o, .deep_powerdown_o);
	host_reader host_u (.clk_sys_i, .pin_i(pin), .oe_i(serial_data_oe_o),
		.serial_clock_o(serial_clock_i));
	// A released pin shows its last bit inverted, so a stale bit cannot pass
	assign pin = serial_data_oe_o ? serial_data_o : ~serial_data_o;
	always #5 clk_sys_i = ~clk_sys_i;
	// Analog side: keep the trial bit while the input is at or above the trial code
	always @(posedge clk_sys_i)
		comparator_i <= (analog_input >= approximation_register_o);
	// Run takes about 5300 cycles; stop a hang well past that
	always @(posedge clk_sys_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors = errors + 1;
			wrap_up();
		end
	end
	task automatic check(input string what, input logic [12:0] exp, input logic [12:0] seen);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Trigger high for 50 ns, falling before the first decision
	task automatic pulse;
		conversion_trigger_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		conversion_trigger_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	// Bounded wait for the end of a conversion, then the acquisition time
	task automatic wait_done;
		for (int i = 0; i < 200 && converting_o !== 1'b0; i++)
			@(negedge clk_sys_i);
		repeat (20) @(posedge clk_sys_i);
	endtask
	task automatic t_convert(input logic [11:0] val, input logic bip, input logic refok);
		logic [12:0] word;
		logic lost;
		analog_input <= val;
		bipolar_i <= bip;
		reference_ok_i <= refok;
		pulse();
		wait_done();
		host_u.read_word(word, lost);
		check("word", {refok, val ^ {bip, 11'h000}}, word);
		check("frame", 1'b0, lost);
		$display("test convert %h ended", val);
	endtask
	// A second edge, then a fall at a decision point, must not disturb the result
	task automatic t_retrigger;
		logic [12:0] word;
		logic lost;
		analog_input <= 12'h5A3;
		bipolar_i <= 1'b0;
		reference_ok_i <= 1'b1;
		pulse();
		repeat (40) @(posedge clk_sys_i);
		conversion_trigger_i <= 1'b1;
		repeat (17) @(posedge clk_sys_i);
		conversion_trigger_i <= 1'b0;
		wait_done();
		host_u.read_word(word, lost);
		check("word", 13'h15A3, word);
		host_u.read_word(word, lost);
		check("extra", 1'b1, lost);
		$display("test retrigger ended");
	endtask
	// Pulses with the clock parked low, a refused start, then a wake pulse
	task automatic t_sleep;
		logic [12:0] word;
		logic lost;
		host_u.park(1'b0);
		@(posedge clk_sys_i);
		for (int n = 1; n <= 4; n++)
		begin
			pulse();
			@(negedge clk_sys_i);
			check("light", n == 2 || n == 3, light_powerdown_o);
			check("deep", n == 4, deep_powerdown_o);
			@(posedge clk_sys_i);
		end
		wait_done();
		pulse();
		@(negedge clk_sys_i);
		check("refused", 1'b0, converting_o);
		@(posedge clk_sys_i);
		host_u.park(1'b1);
		repeat (4) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		check("short wake", 1'b1, deep_powerdown_o);
		@(negedge clk_sys_i);
		check("woken", 1'b0, deep_powerdown_o);
		check("wake bit", 13'h0003, {11'h000, serial_data_oe_o, serial_data_o});
		@(posedge clk_sys_i);
		host_u.read_word(word, lost);
		$display("test sleep ended");
	endtask
	// One word in the shifter plus eight buffered; a tenth start is refused
	task automatic t_full;
		logic [12:0] word;
		logic lost;
		for (int k = 0; k < 10; k++)
		begin
			analog_input <= 12'h1C7 * k[11:0];
			pulse();
			@(negedge clk_sys_i);
			check("started", k < 9, converting_o);
			wait_done();
		end
		for (int k = 0; k < 10; k++)
		begin
			host_u.read_word(word, lost);
			if (k < 9)
				check("queued", {1'b1, 12'h1C7 * k[11:0]}, word);
			check("frame", k == 9, lost);
		end
		$display("test full ended");
	endtask
	initial
	begin
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		t_convert(12'h000, 1'b0, 1'b1);
		t_convert(12'hFFF, 1'b0, 1'b1);
		t_convert(12'hA5C, 1'b0, 1'b0);
		t_convert(12'h7FF, 1'b1, 1'b1);
		t_convert(12'h801, 1'b1, 1'b0);
		t_retrigger();
		t_sleep();
		t_full();
		wrap_up();
	end
endmodule
`default_nettype wire

/* hdl/result_fifo.v */
// Small synchronous FIFO that buffers finished conversion words.
// Assumes one clock; both sides use valid and ready handshakes.
`timescale 1ns/1ns
`default_nettype none

module result_fifo #(
	parameter WIDTH = 13,
	parameter DEPTH = 8,
	parameter ADDR_W = 3
) (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [ADDR_W-1:0] wr_ptr;
	reg [ADDR_W-1:0] rd_ptr;
	reg [ADDR_W:0] count;
	wire push;
	wire pop;

	// Full and empty come straight from the occupancy count;
	// with a power-of-two depth, full is exactly the top count bit
	assign in_ready_o = ~count[ADDR_W];
	assign out_valid_o = (count != {(ADDR_W+1){1'b0}});
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Storage has no reset; only the pointers and the count need a defined value
	always @(posedge clk_sys_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end

	// Pointers wrap naturally because depth is a power of two
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr <= {ADDR_W{1'b0}};
			rd_ptr <= {ADDR_W{1'b0}};
			count <= {(ADDR_W+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push & ~pop)
				count <= count + 1'b1;
			else if (pop & ~push)
				count <= count - 1'b1;
		end
	end

endmodule

`default_nettype wire

/* hdl/sar_adc_consts.vh */
// Shared constants of the serial converter control logic.
// Assumes a 100 MHz system clock and a 12-bit result word.
`ifndef SAR_ADC_CONSTS_VH
`define SAR_ADC_CONSTS_VH

// Clock rate in MHz, used to turn times into cycle counts
`define SYS_CLK_MHZ 32'h0000_0064
// Result width and serial word width (settled flag plus result)
`define RESULT_BITS 12
`define WORD_BITS 13
// Position of the reference settled flag inside the serial word
`define FLAG_POS 12
// Bits in one serial word, at the width of the shift counter
`define WORD_COUNT 4'hD
// Depth of the result buffer
`define FIFO_DEPTH 8
`define FIFO_ADDR_BITS 3
// Time from conversion start to the first bit decision, ns
`define SETTLE_NS 16'h0078
// Time spent on each bit decision, ns
`define DECIDE_NS 16'h0064
// Least clock-high time that wakes the device, ns
`define WAKE_NS 16'h0032
// Trigger pulses with the clock low for each power-down level
`define LIGHT_PULSES 3'h2
`define DEEP_PULSES 3'h4
// Approximation register reset value
`define APPROX_RESET 12'h000

`endif

/* hdl/sar_adc_serial_control.v */
// Control logic of a 12-bit successive-approximation converter.
// Assumes the host's trigger and serial clock are synchronous to clk_sys_i;
// the comparator and reference monitor come from the analog front end.
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_consts.vh"

// What this block does
// - A rising trigger edge starts a conversion unless powered down or the buffer is full; so does a trigger level already high at reset release.
// - The approximation register is cleared at conversion start, before any decision.
// - Trigger edges during a conversion start nothing but still count as power-down pulses with clock low; conversion always completes.
// - Twelve bit decisions are made, most significant bit first down to bit zero.
// - The finished approximation register goes out as a serial word on one pin.
// - The host serial clock paces the output; each bit changes on its edge.
// - With clock low, two trigger pulses give light, four give deep power-down.
// - A clock-high pulse of at least 50 ns wakes from either power-down level.
// - A trigger falling during a bit decision never aborts the running conversion.
// - The serial word carries a settled flag, low while the reference is too low.
// - Unipolar results are natural binary.
// - Bipolar results are two's complement.
module sar_adc_serial_control (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire conversion_trigger_i,
	input wire serial_clock_i,
	input wire comparator_i,
	input wire reference_ok_i,
	input wire bipolar_i,
	output reg [11:0] approximation_register_o,
	output reg sample_hold_o,
	output reg converting_o,
	output reg serial_data_o,
	output reg serial_data_oe_o,
	output reg light_powerdown_o,
	output reg deep_powerdown_o
);

	// Least time in whole cycles, never below one
	function [15:0] ns_to_cycles;
		input [15:0] ns;
		reg [31:0] prod;
		begin
			prod = ({16'h0000, ns} * `SYS_CLK_MHZ + 32'h0000_03E7) / 32'h0000_03E8;
			if (prod == 32'h0000_0000)
				ns_to_cycles = 16'h0001;
			else
				ns_to_cycles = prod[15:0];
		end
	endfunction

	// One-hot mask of a bit position of the approximation register
	function [11:0] bit_mask;
		input [3:0] idx;
		begin
			bit_mask = 12'h001 << idx;
		end
	endfunction

	// Level high now and low on the previous cycle
	function is_rise;
		input now_level;
		input last_level;
		begin
			is_rise = now_level & ~last_level;
		end
	endfunction

	localparam [15:0] SETTLE_CYCLES = ns_to_cycles(`SETTLE_NS);
	localparam [15:0] DECIDE_CYCLES = ns_to_cycles(`DECIDE_NS);
	localparam [15:0] WAKE_CYCLES = ns_to_cycles(`WAKE_NS);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_SETTLE = 2'h1;
	localparam [1:0] ST_DECIDE = 2'h2;
	localparam [1:0] ST_DONE = 2'h3;

	reg [1:0] state;
	reg [15:0] tick_cnt;
	reg [3:0] bit_idx;
	reg trigger_prev;
	reg sclk_prev;
	reg push_valid;
	reg [`WORD_BITS-1:0] push_word;
	reg [2:0] pulse_cnt;
	reg [15:0] high_cnt;
	reg out_active;
	reg [`WORD_BITS-1:0] shift_word;
	reg [3:0] shift_cnt;
	wire trigger_rise;
	wire sclk_rise;
	wire powered_down;
	wire decide_tick;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [`WORD_BITS-1:0] fifo_out_data;
	wire out_take;
	wire [11:0] final_code;

	// Edge memories start low; a serial clock already high at release
	// looks like a rise, which is harmless while there is nothing to shift
	assign trigger_rise = is_rise(conversion_trigger_i, trigger_prev);
	assign sclk_rise = is_rise(serial_clock_i, sclk_prev);
	assign powered_down = light_powerdown_o | deep_powerdown_o;
	assign decide_tick = (tick_cnt == 16'h0001);
	assign out_take = fifo_out_valid & ~out_active;
	// Comparator high keeps the trial bit; the last decision is folded in here
	assign final_code = comparator_i ? approximation_register_o
		: (approximation_register_o & ~bit_mask(bit_idx));

	// Finished words wait here so the host may read them late
	result_fifo #(
		.WIDTH(`WORD_BITS),
		.DEPTH(`FIFO_DEPTH),
		.ADDR_W(`FIFO_ADDR_BITS)
	) u_result_fifo (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(push_word),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(~out_active),
		.out_data_o(fifo_out_data)
	);

	// Conversion sequencer; the divider tick paces each bit decision
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state <= ST_IDLE;
			tick_cnt <= 16'h0000;
			bit_idx <= 4'hB;
			approximation_register_o <= `APPROX_RESET;
			sample_hold_o <= 1'b1;
			converting_o <= 1'b0;
			push_valid <= 1'b0;
			push_word <= {`WORD_BITS{1'b0}};
		end
		else
		begin
			push_valid <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					// Input tracks while idle so acquisition runs between conversions
					sample_hold_o <= 1'b1;
					// A full buffer holds off the start rather than losing a word
					if (trigger_rise && !powered_down && fifo_in_ready)
					begin
						approximation_register_o <= `APPROX_RESET;
						bit_idx <= 4'hB;
						sample_hold_o <= 1'b0;
						converting_o <= 1'b1;
						tick_cnt <= SETTLE_CYCLES;
						state <= ST_SETTLE;
					end
				end
				ST_SETTLE:
				begin
					// Trigger edges are not looked at until the conversion ends
					if (decide_tick)
					begin
						approximation_register_o <= 12'h800;
						tick_cnt <= DECIDE_CYCLES;
						state <= ST_DECIDE;
					end
					else
						tick_cnt <= tick_cnt - 16'h0001;
				end
				ST_DECIDE:
				begin
					// Trigger level changes here cannot abort the decisions
					if (decide_tick)
					begin
						tick_cnt <= DECIDE_CYCLES;
						if (bit_idx == 4'h0)
						begin
							approximation_register_o <= final_code;
							state <= ST_DONE;
						end
						else
						begin
							// Settle this bit, then try the next lower one
							approximation_register_o <= final_code | bit_mask(bit_idx - 4'h1);
							bit_idx <= bit_idx - 4'h1;
						end
					end
					else
						tick_cnt <= tick_cnt - 16'h0001;
				end
				ST_DONE:
				begin
					// Bipolar flips the MSB of the offset code to two's complement
					push_word[11:0] <= bipolar_i
						? {~approximation_register_o[11], approximation_register_o[10:0]}
						: approximation_register_o;
					push_word[`FLAG_POS] <= reference_ok_i;
					push_valid <= 1'b1;
					converting_o <= 1'b0;
					sample_hold_o <= 1'b1;
					state <= ST_IDLE;
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Power-down control: pulses counted while the clock stays low
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			trigger_prev <= 1'b0;
			sclk_prev <= 1'b0;
			pulse_cnt <= 3'h0;
			high_cnt <= 16'h0000;
			light_powerdown_o <= 1'b0;
			deep_powerdown_o <= 1'b0;
		end
		else
		begin
			trigger_prev <= conversion_trigger_i;
			sclk_prev <= serial_clock_i;
			if (serial_clock_i)
			begin
				pulse_cnt <= 3'h0;
				if (high_cnt != WAKE_CYCLES)
					high_cnt <= high_cnt + 16'h0001;
				// Short glitches on the clock do not wake the device
				if (high_cnt + 16'h0001 >= WAKE_CYCLES)
				begin
					light_powerdown_o <= 1'b0;
					deep_powerdown_o <= 1'b0;
				end
			end
			else
			begin
				high_cnt <= 16'h0000;
				if (trigger_rise && pulse_cnt != `DEEP_PULSES)
					pulse_cnt <= pulse_cnt + 3'h1;
				// Second pulse gives light, fourth gives deep power-down
				if (trigger_rise && pulse_cnt + 3'h1 == `LIGHT_PULSES)
					light_powerdown_o <= 1'b1;
				if (trigger_rise && pulse_cnt + 3'h1 == `DEEP_PULSES)
				begin
					light_powerdown_o <= 1'b0;
					deep_powerdown_o <= 1'b1;
				end
			end
		end
	end

	// Serial output: one bit per rising host clock, released after the word
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			out_active <= 1'b0;
			shift_word <= {`WORD_BITS{1'b0}};
			shift_cnt <= 4'h0;
			serial_data_o <= 1'b0;
			serial_data_oe_o <= 1'b0;
		end
		else if (out_take)
		begin
			out_active <= 1'b1;
			shift_word <= fifo_out_data;
			shift_cnt <= 4'h0;
		end
		else if (out_active && sclk_rise)
		begin
			if (shift_cnt == `WORD_COUNT)
			begin
				// Pin released on the edge after the last bit
				serial_data_oe_o <= 1'b0;
				out_active <= 1'b0;
			end
			else
			begin
				serial_data_o <= shift_word[`WORD_BITS-1];
				serial_data_oe_o <= 1'b1;
				shift_word <= {shift_word[`WORD_BITS-2:0], 1'b0};
				shift_cnt <= shift_cnt + 4'h1;
			end
		end
	end

endmodule

`default_nettype wire
